// ### bench/ddr2_precharge_refresh_odt_test.sv
// Self-checking bench for the bank, refresh and termination tracker.
// Assumes the controller model drives pins; expectations come from bench state.
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module ddr2_precharge_refresh_odt_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dpro_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] req_cmd = DPRO_CMD_NOP;
    logic [1:0] req_ba = 2'h0;
    logic [13:0] req_addr = 14'h0000;
    logic req_cke = 1'b1;
    logic desel = 1'b0;
    logic odt = 1'b0;
    wire logic cke, cs_n, ras_n, cas_n, we_n;
    wire logic [1:0] ba;
    wire logic [13:0] addr;
    logic [7:0] bank_state;
    logic [3:0] bank_ready;
    logic refresh_pulse, self_refresh, dll_on, read_ok, term_dq, term_dqs, term_rdqs, cmd_error;
    logic [13:0] refresh_row;
    logic [1:0] rtt_sel;
    int bad_count = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'h00012e51;
    logic [1:0] exp_st [4];
    logic [1:0] b;
    logic [13:0] row;
    int n;

    always #10 clk_sys = ~clk_sys;

    dpro_ctrl_model i_ctrl (.req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr),
        .req_cke(req_cke), .desel(desel), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
    dpro_core i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt),
        .bank_state(bank_state), .bank_ready(bank_ready), .refresh_pulse(refresh_pulse),
        .refresh_row(refresh_row), .self_refresh(self_refresh), .dll_on(dll_on),
        .read_ok(read_ok), .rtt_sel(rtt_sel), .term_dq(term_dq), .term_dqs(term_dqs),
        .term_rdqs(term_rdqs), .cmd_error(cmd_error));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] packed_exp();
        return {exp_st[3], exp_st[2], exp_st[1], exp_st[0]};
    endfunction

    // Called at a falling edge; returns one edge later with the effect visible
    task automatic run(input logic [2:0] c, input logic [1:0] k, input logic [13:0] a);
        req_cmd = c;
        req_ba = k;
        req_addr = a;
        @(negedge clk_sys);
    endtask

    task automatic nop(input int cnt);
        req_cmd = DPRO_CMD_NOP;
        repeat (cnt) begin
            seed = xs(seed);
            desel = seed[0];
            @(negedge clk_sys);
        end
    endtask

    task automatic summarize();
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        summarize();
    end

    initial begin
        foreach (exp_st[i]) exp_st[i] = 2'h0;
        repeat (8) @(negedge clk_sys);
        sys_rst = 1'b0;
        `CHK({bank_state, dll_on, read_ok, self_refresh}, 11'h006)
        run(DPRO_CMD_ACT, 2'h0, 14'h0123);
        `CHK(bank_state[1:0], 2'h1)
        run(DPRO_CMD_PRE, 2'h0, 14'h0000);
        `CHK(bank_state[1:0], 2'h2)
        run(DPRO_CMD_PRE, 2'h0, 14'h0000);
        `CHK({bank_state[1:0], cmd_error}, 3'h4)
        run(DPRO_CMD_PRE, 2'h3, 14'h0000);
        `CHK({bank_state, cmd_error}, 9'h100)
        nop(1);
        `CHK(bank_state, 8'h00)
        for (int i = 1; i < 4; i++) run(DPRO_CMD_ACT, 2'(i), 14'h0000);
        run(DPRO_CMD_PRE, 2'h0, 14'h0400);
        `CHK(bank_state, 8'haa)
        nop(1);
        `CHK({bank_state, bank_ready}, 12'h00f)
        // Random open and close traffic; a closed bank waits one edge first
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            b = seed[1:0];
            exp_st[b] = (exp_st[b] == 2'h0) ? 2'h1 : 2'h2;
            run((exp_st[b] == 2'h1) ? DPRO_CMD_ACT : DPRO_CMD_PRE, b, seed[15:2] & 14'h3bff);
            `CHK(bank_state, packed_exp())
            foreach (exp_st[j]) if (exp_st[j] == 2'h2) exp_st[j] = 2'h0;
            nop(1);
        end
        run(DPRO_CMD_PRE, 2'h0, 14'h0400);
        nop(2);
        run(DPRO_CMD_RD, 2'h2, 14'h0000);
        `CHK(cmd_error, 1'b1)
        run(DPRO_CMD_ACT, 2'h0, 14'h0000);
        run(DPRO_CMD_ACT, 2'h1, 14'h0000);
        run(DPRO_CMD_RD, 2'h0, 14'h0400);
        run(DPRO_CMD_WR, 2'h1, 14'h0000);
        `CHK(cmd_error, 1'b0)
        nop(8);
        `CHK(bank_state, 8'h04)
        run(DPRO_CMD_PRE, 2'h1, 14'h0000);
        run(DPRO_CMD_ACT, 2'h1, 14'h0000);
        `CHK({bank_state[3:2], cmd_error}, 3'h2)
        run(DPRO_CMD_PRE, 2'h1, 14'h0000);
        nop(2);
        // Refresh only from all idle, address bits random
        for (int i = 0; i < 4; i++) begin
            row = refresh_row;
            seed = xs(seed);
            run(DPRO_CMD_REF, seed[1:0], seed[15:2]);
            `CHK(refresh_pulse, 1'b1)
            `CHK(refresh_row, row + 14'h0001)
            nop(8);
            `CHK(refresh_pulse, 1'b0)
        end
        run(DPRO_CMD_REF, 2'h0, 14'h0000);
        run(DPRO_CMD_REF, 2'h0, 14'h0000);
        `CHK(cmd_error, 1'b1)
        nop(8);
        run(DPRO_CMD_MRS, DPRO_BA_EMR1, 14'h0004);
        req_cke = 1'b0;
        nop(1);
        `CHK(cmd_error, 1'b1)
        req_cke = 1'b1;
        nop(3);
        odt = 1'b1;
        nop(3);
        `CHK({rtt_sel, term_dq, term_dqs, term_rdqs}, 5'h0f)
        odt = 1'b0;
        nop(3);
        `CHK({term_dq, term_dqs, term_rdqs}, 3'h0)
        odt = 1'b1;
        req_cke = 1'b0;
        run(DPRO_CMD_REF, 2'h0, 14'h0000);
        `CHK({self_refresh, dll_on}, 2'h2)
        n = 0;
        nop(1);
        repeat (800) begin
            @(negedge clk_sys);
            n += int'(refresh_pulse);
        end
        `CHK(n >= 2, 1'b1)
        `CHK(term_dq, 1'b0)
        req_cke = 1'b1;
        nop(2);
        `CHK({self_refresh, dll_on}, 2'h1)
        nop(150);
        `CHK({read_ok, term_dq}, 2'h1)
        run(DPRO_CMD_ACT, 2'h0, 14'h0000);
        run(DPRO_CMD_RD, 2'h0, 14'h0000);
        `CHK(cmd_error, 1'b1)
        nop(60);
        `CHK(read_ok, 1'b1)
        run(DPRO_CMD_RD, 2'h0, 14'h0000);
        `CHK(cmd_error, 1'b0)
        odt = 1'b0;
        summarize();
    end
endmodule
`default_nettype wire

// ### bench/dpro_ctrl_model.sv
// Controller-side pin driver facing the tracker.
// Assumes the bench changes requests at the falling edge of clk_sys.
`default_nettype none
module dpro_ctrl_model (
    // Requests
    input wire logic [2:0] req_cmd,
    input wire logic [dpro_pkg::DPRO_BA_W-1:0] req_ba,
    input wire logic [dpro_pkg::DPRO_ROW_W-1:0] req_addr,
    input wire logic req_cke,
    input wire logic desel,
    // Command pins
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [dpro_pkg::DPRO_BA_W-1:0] ba,
    output logic [dpro_pkg::DPRO_ROW_W-1:0] addr
);
    timeunit 1ns;
    timeprecision 1ps;
    import dpro_pkg::*;
    assign cke = req_cke;
    // Deselect may stand in for any NOP
    assign cs_n = desel && (req_cmd == DPRO_CMD_NOP);
    assign {ras_n, cas_n, we_n} = req_cmd;
    assign ba = req_ba;
    // Address means nothing on a NOP, so it is driven inverted there
    assign addr = (req_cmd == DPRO_CMD_NOP) ? ~req_addr : req_addr;
endmodule
`default_nettype wire

// ### hdl/dpro_core.sv
// Device-side tracker of bank precharge, auto and self refresh, and termination.
// Assumes controller pins synchronous to clk_sys; reset from the power-up sequence.
// What this block does
// - Precharge closes one selected bank or all banks, returning them idle.
// - Reads or writes to other banks allowed during concurrent auto precharge.
// - Precharge to an idle or precharging bank is legal.
// - Precharge interval is timed from the latest precharge to that bank.
// - Refresh row comes from an internal counter; address inputs ignored.
// - Self refresh keeps data on internal timing, without the external clock.
// - DLL turns off on self refresh entry and on again on exit.
// - Extended mode write sets termination value; termination input switches it.
// - Termination works in active, standby and power-down, not self refresh.
// - Enabled termination applies to data, strobes and read strobes alike.
`default_nettype none
module dpro_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [dpro_pkg::DPRO_BA_W-1:0] ba,
    input wire logic [dpro_pkg::DPRO_ROW_W-1:0] addr,
    input wire logic odt,
    // Status
    output logic [2*dpro_pkg::DPRO_BANKS-1:0] bank_state,
    output logic [dpro_pkg::DPRO_BANKS-1:0] bank_ready,
    output logic refresh_pulse,
    output logic [dpro_pkg::DPRO_ROW_W-1:0] refresh_row,
    output logic self_refresh,
    output logic dll_on,
    output logic read_ok,
    output logic [1:0] rtt_sel,
    output logic term_dq,
    output logic term_dqs,
    output logic term_rdqs,
    output logic cmd_error
);
    import dpro_pkg::*;

    typedef struct packed {
        dpro_bank_t [DPRO_BANKS-1:0] bst;
        logic [DPRO_BANKS-1:0][7:0] btmr;
        dpro_mode_t mode;
        logic [15:0] mtmr;
        logic [7:0] xtmr;
        logic [DPRO_ROW_W-1:0] row;
        logic ref_p;
        logic dll;
        logic [1:0] rtt;
        logic [7:0] modt;
        logic term;
        logic err;
        logic [DPRO_BANKS-1:0] rdy;
        logic sref;
        logic rok;
    } dpro_state_t;

    dpro_state_t s_reg;
    dpro_state_t s_next;
    logic [2:0] cmd;
    logic all_idle;
    logic pre0_hit;

    always_comb begin
        cmd = cs_n ? DPRO_CMD_NOP : {ras_n, cas_n, we_n};
        all_idle = 1'b1;
        for (int i = 0; i < DPRO_BANKS; i++) begin
            if (s_reg.bst[i] != DPRO_B_IDLE) begin
                all_idle = 1'b0;
            end
        end
    end

    always_comb begin
        s_next = s_reg;
        s_next.ref_p = 1'b0;
        s_next.err = 1'b0;
        // Per-bank timers count down; a precharging bank turns idle at zero
        for (int i = 0; i < DPRO_BANKS; i++) begin
            if (s_reg.btmr[i] != 8'h00) begin
                s_next.btmr[i] = s_reg.btmr[i] - 8'h01;
            end else if (s_reg.bst[i] == DPRO_B_PRECH) begin
                s_next.bst[i] = DPRO_B_IDLE;
            end
        end
        if (s_reg.modt != 8'h00) begin
            s_next.modt = s_reg.modt - 8'h01;
        end
        if (s_reg.xtmr != 8'h00) begin
            s_next.xtmr = s_reg.xtmr - 8'h01;
        end
        case (s_reg.mode)
            DPRO_M_NORM, DPRO_M_AREF: begin
                if (s_reg.mode == DPRO_M_AREF) begin
                    if (s_reg.mtmr == 16'h0000) begin
                        s_next.mode = DPRO_M_NORM;
                    end else begin
                        s_next.mtmr = s_reg.mtmr - 16'h0001;
                    end
                end
                if (cke && cmd == DPRO_CMD_PRE) begin
                    // Legal on idle or precharging banks; timer restarts
                    for (int i = 0; i < DPRO_BANKS; i++) begin
                        if (addr[DPRO_AP_BIT] || ba == DPRO_BA_W'(i)) begin
                            s_next.bst[i] = DPRO_B_PRECH;
                            s_next.btmr[i] = 8'(DPRO_TRP_CYC - 1);
                        end
                    end
                end else if (cke && cmd == DPRO_CMD_ACT) begin
                    // A precharge whose timer has run out already meets tRP
                    if (s_reg.bst[ba] == DPRO_B_ACTIVE || s_reg.btmr[ba] != 8'h00) begin
                        s_next.err = 1'b1;
                    end
                    s_next.bst[ba] = DPRO_B_ACTIVE;
                end else if (cke && (cmd == DPRO_CMD_RD || cmd == DPRO_CMD_WR)) begin
                    // Other banks stay untouched while one auto precharges
                    if (s_reg.bst[ba] != DPRO_B_ACTIVE) begin
                        s_next.err = 1'b1;
                    end
                    if (cmd == DPRO_CMD_RD && s_reg.xtmr != 8'h00) begin
                        s_next.err = 1'b1;
                    end
                    if (addr[DPRO_AP_BIT]) begin
                        s_next.bst[ba] = DPRO_B_PRECH;
                        s_next.btmr[ba] = 8'(DPRO_TRP_CYC + 3);
                    end
                end else if (cmd == DPRO_CMD_REF) begin
                    if (!all_idle || s_reg.mode == DPRO_M_AREF) begin
                        s_next.err = 1'b1;
                    end
                    // One row per command from the internal counter
                    s_next.row = s_reg.row + 14'h0001;
                    s_next.ref_p = 1'b1;
                    if (!cke) begin
                        // Refresh encoding with CKE low enters self refresh
                        s_next.mode = DPRO_M_SREF;
                        s_next.dll = 1'b0;
                        s_next.term = 1'b0;
                        s_next.mtmr = 16'(DPRO_SREF_CYC - 1);
                    end else begin
                        s_next.mode = DPRO_M_AREF;
                        s_next.mtmr = 16'(DPRO_TRFC_CYC - 1);
                    end
                end else if (cke && cmd == DPRO_CMD_MRS && ba == DPRO_BA_EMR1) begin
                    // Termination value from extended mode bits A6 and A2
                    s_next.rtt = {addr[6], addr[2]};
                    s_next.modt = 8'(DPRO_MOD_CYC);
                    if (!all_idle) begin
                        s_next.err = 1'b1;
                    end
                end
                if (s_reg.modt != 8'h00 && !cke) begin
                    s_next.err = 1'b1;
                end
                // Termination follows the input in active, standby and power-down
                s_next.term = odt && (s_next.rtt != 2'h0) && (s_next.mode != DPRO_M_SREF);
            end
            DPRO_M_SREF: begin
                // Internal timer refreshes rows without the external clock
                if (s_reg.mtmr == 16'h0000) begin
                    s_next.row = s_reg.row + 14'h0001;
                    s_next.ref_p = 1'b1;
                    s_next.mtmr = 16'(DPRO_SREF_CYC - 1);
                end else begin
                    s_next.mtmr = s_reg.mtmr - 16'h0001;
                end
                s_next.term = 1'b0;
                if (cke) begin
                    if (cmd != DPRO_CMD_NOP) begin
                        s_next.err = 1'b1;
                    end
                    s_next.mode = DPRO_M_XSR;
                    s_next.dll = 1'b1;
                    s_next.xtmr = 8'(DPRO_TXSRD_CYC - 1);
                    s_next.mtmr = 16'(DPRO_TRFC_CYC - 1);
                end
            end
            default: begin
                // Exit interval: only NOP or deselect allowed
                if (cmd != DPRO_CMD_NOP) begin
                    s_next.err = 1'b1;
                end
                if (s_reg.mtmr == 16'h0000) begin
                    s_next.mode = DPRO_M_NORM;
                end else begin
                    s_next.mtmr = s_reg.mtmr - 16'h0001;
                end
            end
        endcase
        // Status outputs are registered so that the pins carry no decode logic
        for (int i = 0; i < DPRO_BANKS; i++) begin
            s_next.rdy[i] = (s_next.bst[i] == DPRO_B_IDLE);
        end
        s_next.sref = (s_next.mode == DPRO_M_SREF);
        s_next.rok = (s_next.xtmr == 8'h00);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int i = 0; i < DPRO_BANKS; i++) begin
                s_reg.bst[i] <= DPRO_B_IDLE;
            end
            s_reg.btmr <= {DPRO_BANKS{DPRO_TMR_RST}};
            s_reg.mode <= DPRO_M_NORM;
            s_reg.mtmr <= 16'h0000;
            s_reg.xtmr <= DPRO_TMR_RST;
            s_reg.row <= DPRO_ROW_RST;
            s_reg.ref_p <= 1'b0;
            s_reg.dll <= 1'b1;
            s_reg.rtt <= 2'h0;
            s_reg.modt <= DPRO_TMR_RST;
            s_reg.term <= 1'b0;
            s_reg.err <= 1'b0;
            s_reg.rdy <= {DPRO_BANKS{1'b1}};
            s_reg.sref <= 1'b0;
            s_reg.rok <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        for (int i = 0; i < DPRO_BANKS; i++) begin
            bank_state[2*i +: 2] = s_reg.bst[i];
        end
    end
    assign bank_ready = s_reg.rdy;
    assign refresh_pulse = s_reg.ref_p;
    assign refresh_row = s_reg.row;
    assign self_refresh = s_reg.sref;
    assign dll_on = s_reg.dll;
    assign read_ok = s_reg.rok;
    assign rtt_sel = s_reg.rtt;
    // One enable drives every terminated line group
    assign term_dq = s_reg.term;
    assign term_dqs = s_reg.term;
    assign term_rdqs = s_reg.term;
    assign cmd_error = s_reg.err;

    // Precharge reaching bank 0, kept as a signal so that properties may negate it
    assign pre0_hit = cke && !cs_n && {ras_n, cas_n, we_n} == DPRO_CMD_PRE
        && (addr[DPRO_AP_BIT] || ba == 2'h0) && s_reg.mode != DPRO_M_SREF
        && s_reg.mode != DPRO_M_XSR;

    sequence s_pre0;
        pre0_hit;
    endsequence

    property p_pre_closes;
        @(posedge clk_sys) disable iff (sys_rst)
        s_pre0 |=> bank_state[1:0] == DPRO_B_PRECH;
    endproperty
    a_pre_closes: assert property (p_pre_closes) else $error("precharge did not close bank");

    property p_pre_timed;
        @(posedge clk_sys) disable iff (sys_rst)
        s_pre0 ##1 (!pre0_hit && !(cke && !cs_n && !ras_n && cas_n && we_n))[*1]
            |-> !bank_ready[0];
    endproperty
    a_pre_timed: assert property (p_pre_timed) else $error("bank idle before tRP");

    property p_pre_idle;
        @(posedge clk_sys) disable iff (sys_rst)
        ((bank_state[1:0] == DPRO_B_IDLE) and s_pre0) |=> !cmd_error;
    endproperty
    a_pre_idle: assert property (p_pre_idle) else $error("precharge to idle bank flagged");

    property p_ref_row;
        @(posedge clk_sys) disable iff (sys_rst)
        refresh_pulse |-> refresh_row == $past(refresh_row) + 14'h0001;
    endproperty
    a_ref_row: assert property (p_ref_row) else $error("refresh row not from counter");

    property p_sref_dll;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(self_refresh) |-> !dll_on && !term_dq;
    endproperty
    a_sref_dll: assert property (p_sref_dll) else $error("dll or odt on in self refresh");

    property p_sref_noterm;
        @(posedge clk_sys) disable iff (sys_rst)
        self_refresh |-> !term_dq && !term_dqs && !term_rdqs;
    endproperty
    a_sref_noterm: assert property (p_sref_noterm) else $error("termination in self refresh");

    property p_sref_enter;
        @(posedge clk_sys) disable iff (sys_rst)
        (s_reg.mode == DPRO_M_NORM && !cke && !cs_n && {ras_n, cas_n, we_n} == DPRO_CMD_REF)
            |=> self_refresh;
    endproperty
    a_sref_enter: assert property (p_sref_enter) else $error("self refresh not entered");

    property p_xsr_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (self_refresh && cke) |=> !read_ok [*8];
    endproperty
    a_xsr_read: assert property (p_xsr_read) else $error("read allowed too early");

    property p_term_equal;
        @(posedge clk_sys) disable iff (sys_rst)
        term_dq == term_dqs && term_dqs == term_rdqs;
    endproperty
    a_term_equal: assert property (p_term_equal) else $error("termination groups differ");
endmodule
`default_nettype wire

// ### shared/dpro_pkg.sv
// Constants, command codes and state types for the bank, refresh and termination tracker.
// Assumes one 50 MHz clock and commands sampled on its rising edge.
`default_nettype none
package dpro_pkg;
    localparam int DPRO_BANKS = 4;
    localparam int DPRO_ROW_W = 14;
    localparam int DPRO_BA_W = 2;
    localparam int DPRO_CLK_NS = 20;
    // Least times, in ns, rounded up to whole cycles; DPRO_TXSRD_CYC is set in cycles
    localparam int DPRO_TRP_NS = 15;
    localparam int DPRO_TRP_CYC = (DPRO_TRP_NS + DPRO_CLK_NS - 1) / DPRO_CLK_NS;
    localparam int DPRO_TRFC_NS = 105;
    localparam int DPRO_TRFC_CYC = (DPRO_TRFC_NS + DPRO_CLK_NS - 1) / DPRO_CLK_NS;
    localparam int DPRO_TXSRD_CYC = 200;
    localparam int DPRO_MOD_NS = 12;
    localparam int DPRO_MOD_CYC = (DPRO_MOD_NS + DPRO_CLK_NS - 1) / DPRO_CLK_NS;
    // Internal self refresh interval, about 7.8 us
    localparam int DPRO_SREF_NS = 7800;
    localparam int DPRO_SREF_CYC = DPRO_SREF_NS / DPRO_CLK_NS;
    localparam logic [7:0] DPRO_TMR_RST = 8'h00;
    localparam logic [DPRO_ROW_W-1:0] DPRO_ROW_RST = 14'h0000;
    // Command encodings {ras_n, cas_n, we_n}
    localparam logic [2:0] DPRO_CMD_MRS = 3'h0;
    localparam logic [2:0] DPRO_CMD_REF = 3'h1;
    localparam logic [2:0] DPRO_CMD_PRE = 3'h2;
    localparam logic [2:0] DPRO_CMD_ACT = 3'h3;
    localparam logic [2:0] DPRO_CMD_WR = 3'h4;
    localparam logic [2:0] DPRO_CMD_RD = 3'h5;
    localparam logic [2:0] DPRO_CMD_NOP = 3'h7;
    localparam int DPRO_AP_BIT = 10;
    localparam logic [DPRO_BA_W-1:0] DPRO_BA_EMR1 = 2'h1;
    typedef enum logic [1:0] {DPRO_B_IDLE, DPRO_B_ACTIVE, DPRO_B_PRECH} dpro_bank_t;
    typedef enum logic [1:0] {DPRO_M_NORM, DPRO_M_AREF, DPRO_M_SREF, DPRO_M_XSR} dpro_mode_t;
endpackage
`default_nettype wire
